// ==== sync_seq_map.svh ====
// offsets, field positions, reset values and timing counts for the startup/sync link
`ifndef SYNC_SEQ_MAP_SVH
`define SYNC_SEQ_MAP_SVH
// ==========================================================================
// device register indices
`define IO_CFG_ADDR        5'h1A
`define SYNC_CTRL_ADDR     5'h05
`define SYNC_SEL_A_ADDR    5'h16
`define SYNC_SEL_B_ADDR    5'h17
`define SHADOW_FIRST_ADDR  5'h06
`define SHADOW_LAST_ADDR   5'h0D
// ==========================================================================
// fields and reset values
`define IO_CFG_MODE_LSB    0
`define IO_CFG_MODE_REQ    2'h2
`define IO_CFG_RESET       8'h00
`define SYNC_CTRL_SW_BIT   0
`define SYNC_CTRL_MODE_LSB 1
`define SYNC_SEL_SRC_LSB   0
`define SYNC_SEL_RESET     8'h00
// ==========================================================================
// timing
`define RESET_LOW_NS       25
`define CLK_PERIOD_NS      4
`define RESET_LOW_CYC      ((`RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLK_SETTLE_CYC     16
// ==========================================================================
// host command register indices
`define HOST_CTRL_ADDR     4'h0
`define HOST_STAT_ADDR     4'h1
`define HOST_WADDR_ADDR    4'h2
`define HOST_WDATA_ADDR    4'h3
`endif

// ==== sync_seq_pkg.sv ====
// types used by the device end of the startup/sync link
`default_nettype none
package sync_seq_pkg;
  typedef enum logic [1:0] {SRC_TXGATE, SRC_STROBE, SRC_SOFT, SRC_NONE} sync_src_t;
  typedef enum logic [1:0] {CLK_EXTERNAL, CLK_DUAL_ASYNC, CLK_DUAL_SYNC, CLK_RSVD} clk_mode_t;
endpackage
`default_nettype wire

// ==== sync_seq_if.sv ====
// link between host sequencer and device: reset, clock gate, register port, sync pins
`timescale 1ns/1ns
`default_nettype none
interface sync_seq_if;
  logic       reset_low_pin;
  logic       sample_clock_en;
  logic       reg_wr;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       transmit_gate_pin;
  logic       align_strobe_pin;
  logic       data_valid;
  logic       dev_ready;
  modport host (output reset_low_pin, sample_clock_en, reg_wr, reg_addr, reg_wdata,
                output transmit_gate_pin, align_strobe_pin, data_valid, input dev_ready);
  modport dev  (input reset_low_pin, sample_clock_en, reg_wr, reg_addr, reg_wdata,
                input transmit_gate_pin, align_strobe_pin, data_valid, output dev_ready);
endinterface
`default_nettype wire

// ==== sync_src_pick.sv ====
// sync source selection and edge detection for the device
`timescale 1ns/1ns
`default_nettype none
module sync_src_pick (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // sources
  input  wire sync_seq_pkg::sync_src_t sel,
  input  wire logic                  tx_gate,
  input  wire logic                  strobe,
  input  wire logic                  soft_pulse,
  // event
  output logic                       sync_event
);
  logic tx_q_r, tx_q_nxt, st_q_r, st_q_nxt;

  always_comb begin
    tx_q_nxt = tx_gate;
    st_q_nxt = strobe;
    case (sel)
      sync_seq_pkg::SRC_TXGATE: sync_event = tx_gate & ~tx_q_r;
      sync_seq_pkg::SRC_STROBE: sync_event = strobe & ~st_q_r;
      sync_seq_pkg::SRC_SOFT:   sync_event = soft_pulse;
      default:                  sync_event = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_q_r <= 1'b0;
      st_q_r <= 1'b0;
    end else begin
      tx_q_r <= tx_q_nxt;
      st_q_r <= st_q_nxt;
    end
  end
endmodule // sync_src_pick
`default_nettype wire

// ==== dac_sync_device.sv ====
// device end: configuration registers, shadow transfer on sync, aligned output latency
// Behaviour
// - host holds reset low at least 25 ns
// - host waits for stable clock before programming
// - host writes io config low bits 10
// - io config low bits reset to 00
// - host syncs after programming, then sends data
// - sync source chosen by select registers
// - shadow registers copy to active on sync
// - system syncs all devices together
// - multi-device sync uses pins, not software
// - async clock modes align within one cycle
// - dual sync clock mode gives constant latency
`timescale 1ns/1ns
`default_nettype none
`include "sync_seq_map.svh"
module dac_sync_device #(
  parameter int SHADOW_N = `SHADOW_LAST_ADDR - `SHADOW_FIRST_ADDR + 1
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // link
  sync_seq_if.dev          lnk,
  // user side
  output logic [7:0]       active_cfg [SHADOW_N],
  output logic [7:0]       io_cfg,
  output logic             cfg_ok,
  output logic             sync_seen,
  output logic             out_valid,
  output logic [1:0]       out_skew
);
  // ========================================================================
  // parameter check
  // the shadow window is fixed by the register map, so only one size works
  if (SHADOW_N != `SHADOW_LAST_ADDR - `SHADOW_FIRST_ADDR + 1) begin : g_bad_shadow_n
    $error("SHADOW_N must match the shadow range");
  end

  // ========================================================================
  // registers
  localparam int IDX_W = $clog2(SHADOW_N);

  logic [7:0] io_cfg_r,   io_cfg_nxt;
  logic [7:0] sel_a_r,    sel_a_nxt;
  logic [7:0] sel_b_r,    sel_b_nxt;
  logic [7:0] mode_r,     mode_nxt;
  logic [7:0] pend_r      [SHADOW_N];
  logic [7:0] pend_nxt    [SHADOW_N];
  logic [7:0] act_r       [SHADOW_N];
  logic [7:0] act_nxt     [SHADOW_N];
  logic       soft_r,     soft_nxt;
  logic       seen_r,     seen_nxt;
  logic       ok_r,       ok_nxt;
  logic       valid_r,    valid_nxt;
  logic [1:0] skew_r,     skew_nxt;
  logic [1:0] phase_r,    phase_nxt;
  logic       in_reset;
  logic       wr_ok;
  logic       sync_event;
  sync_seq_pkg::sync_src_t src;

  function automatic logic in_shadow(input logic [4:0] a);
    in_shadow = (a >= `SHADOW_FIRST_ADDR) && (a <= `SHADOW_LAST_ADDR);
  endfunction

  // slot of a register index inside the shadow window
  function automatic logic [IDX_W-1:0] shadow_idx(input logic [4:0] a);
    logic [4:0] off;
    off        = a - `SHADOW_FIRST_ADDR;
    shadow_idx = off[IDX_W-1:0];
  endfunction

  // device is held while its reset pin is low
  assign in_reset = ~lnk.reset_low_pin;
  // a write without a running sample clock never reaches the device flops;
  // the host has to start the clock first
  assign wr_ok    = lnk.reg_wr & lnk.sample_clock_en;
  // select a picks the source unless b overrides with a nonzero code
  assign src = (sel_b_r[1:0] != 2'h0) ? sync_seq_pkg::sync_src_t'(sel_b_r[1:0] - 2'h1)
                                      : sync_seq_pkg::sync_src_t'(sel_a_r[1:0]);

  // ========================================================================
  // sync source
  sync_src_pick u_pick (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .sel        (src),
    .tx_gate    (lnk.transmit_gate_pin),
    .strobe     (lnk.align_strobe_pin),
    .soft_pulse (soft_r),
    .sync_event (sync_event)
  );

  // ========================================================================
  // register file and shadow copy
  always_comb begin
    io_cfg_nxt = io_cfg_r;
    sel_a_nxt  = sel_a_r;
    sel_b_nxt  = sel_b_r;
    mode_nxt   = mode_r;
    pend_nxt   = pend_r;
    act_nxt    = act_r;
    soft_nxt   = 1'b0;
    seen_nxt   = seen_r;
    // shadow contents survive the link reset; only live settings clear
    if (in_reset) begin
      io_cfg_nxt = `IO_CFG_RESET;
      sel_a_nxt  = `SYNC_SEL_RESET;
      sel_b_nxt  = `SYNC_SEL_RESET;
      mode_nxt   = 8'h00;
      seen_nxt   = 1'b0;
    end else begin
      if (wr_ok) begin
        case (lnk.reg_addr)
          `IO_CFG_ADDR:     io_cfg_nxt = lnk.reg_wdata;
          `SYNC_SEL_A_ADDR: sel_a_nxt  = lnk.reg_wdata;
          `SYNC_SEL_B_ADDR: sel_b_nxt  = lnk.reg_wdata;
          `SYNC_CTRL_ADDR: begin
            mode_nxt = lnk.reg_wdata;
            soft_nxt = lnk.reg_wdata[`SYNC_CTRL_SW_BIT];
          end
          default: begin
            if (in_shadow(lnk.reg_addr))
              pend_nxt[shadow_idx(lnk.reg_addr)] = lnk.reg_wdata;
          end
        endcase
      end
      // a write landing with the sync is carried into the copy as well
      if (sync_event) begin
        act_nxt  = pend_nxt;
        seen_nxt = 1'b1;
      end
    end
    // registered so the mode flag cannot glitch while a write lands
    ok_nxt = (io_cfg_nxt[`IO_CFG_MODE_LSB +: 2] == `IO_CFG_MODE_REQ);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_cfg_r <= `IO_CFG_RESET;
      sel_a_r  <= `SYNC_SEL_RESET;
      sel_b_r  <= `SYNC_SEL_RESET;
      mode_r   <= 8'h00;
      soft_r   <= 1'b0;
      seen_r   <= 1'b0;
      ok_r     <= 1'b0;
      for (int i = 0; i < SHADOW_N; i++) begin
        pend_r[i] <= 8'h00;
        act_r[i]  <= 8'h00;
      end
    end else begin
      io_cfg_r <= io_cfg_nxt;
      sel_a_r  <= sel_a_nxt;
      sel_b_r  <= sel_b_nxt;
      mode_r   <= mode_nxt;
      soft_r   <= soft_nxt;
      seen_r   <= seen_nxt;
      ok_r     <= ok_nxt;
      pend_r   <= pend_nxt;
      act_r    <= act_nxt;
    end
  end

  // ========================================================================
  // output alignment: a free phase counter models the fifo crossing
  // in async modes the first output lands on the phase seen at sync, up to
  // one cycle late; dual sync mode pins it to zero skew
  always_comb begin
    phase_nxt = phase_r + 2'h1;
    valid_nxt = seen_r & lnk.data_valid;
    skew_nxt  = skew_r;
    if (in_reset) begin
      valid_nxt = 1'b0;
      skew_nxt  = 2'h0;
    end else if (sync_event) begin
      if (sync_seq_pkg::clk_mode_t'(mode_r[`SYNC_CTRL_MODE_LSB +: 2]) == sync_seq_pkg::CLK_DUAL_SYNC)
        skew_nxt = 2'h0;
      else
        skew_nxt = {1'b0, phase_r[0]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_r <= 2'h0;
      valid_r <= 1'b0;
      skew_r  <= 2'h0;
    end else begin
      phase_r <= phase_nxt;
      valid_r <= valid_nxt;
      skew_r  <= skew_nxt;
    end
  end

  // ========================================================================
  // outputs
  // ready needs both the mode setting and a sync, so data never meets stale settings
  assign active_cfg    = act_r;
  assign io_cfg        = io_cfg_r;
  assign cfg_ok        = ok_r;
  assign sync_seen     = seen_r;
  assign out_valid     = valid_r;
  assign out_skew      = skew_r;
  assign lnk.dev_ready = seen_r & cfg_ok;
endmodule // dac_sync_device
`default_nettype wire

// ==== dac_sync_host.sv ====
// host end: reset pulse, clock start, register programming, sync, then data
`timescale 1ns/1ns
`default_nettype none
`include "sync_seq_map.svh"
module dac_sync_host #(
  parameter int RESET_CYC  = `RESET_LOW_CYC,
  parameter int SETTLE_CYC = `CLK_SETTLE_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // link
  sync_seq_if.host         lnk,
  // software port
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [7:0]       rdata
);
  // the one shared counter is 16 bits wide and a zero count would wrap and hold its state for 65536 cycles
  if (RESET_CYC < 1 || SETTLE_CYC < 1 || RESET_CYC > 16'hFFFF || SETTLE_CYC > 16'hFFFF) begin : g_bad_counts
    $error("counts must fit the 16-bit counter and be at least one");
  end
  typedef enum logic [2:0] {S_IDLE, S_RESET, S_CLOCK, S_PROG, S_SYNC, S_DATA} st_t;
  st_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [4:0]  pa_r, pa_nxt;
  logic [7:0]  pd_r, pd_nxt, rd_r, rd_nxt;
  logic        wr_r, wr_nxt, go_r, go_nxt, tx_r, tx_nxt, sb_r, sb_nxt, pin_r, pin_nxt;

  // ctrl: bit0 start, bit1 issue write, bit2 sync, bit3 use strobe pin
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    pa_nxt  = pa_r;
    pd_nxt  = pd_r;
    wr_nxt  = 1'b0;
    go_nxt  = 1'b0;
    tx_nxt  = tx_r;
    sb_nxt  = 1'b0;
    pin_nxt = pin_r;
    rd_nxt  = 8'h00;
    if (wr && addr == `HOST_WADDR_ADDR) pa_nxt = wdata[4:0];
    if (wr && addr == `HOST_WDATA_ADDR) pd_nxt = wdata;
    if (wr && addr == `HOST_CTRL_ADDR) pin_nxt = wdata[3];
    if (rd) begin
      case (addr)
        `HOST_STAT_ADDR:  rd_nxt = {4'h0, lnk.dev_ready, 3'(st_r)};
        `HOST_WADDR_ADDR: rd_nxt = {3'h0, pa_r};
        `HOST_WDATA_ADDR: rd_nxt = pd_r;
        default:          rd_nxt = 8'h00;
      endcase
    end
    case (st_r)
      S_IDLE: if (wr && addr == `HOST_CTRL_ADDR && wdata[0]) begin
        st_nxt  = S_RESET;
        cnt_nxt = 16'(RESET_CYC);
        tx_nxt  = 1'b0;
      end
      S_RESET: begin
        cnt_nxt = cnt_r - 16'h1;
        if (cnt_r == 16'h1) begin
          st_nxt  = S_CLOCK;
          cnt_nxt = 16'(SETTLE_CYC);
        end
      end
      S_CLOCK: begin
        cnt_nxt = cnt_r - 16'h1;
        if (cnt_r == 16'h1) begin
          st_nxt = S_PROG;
          pa_nxt = `IO_CFG_ADDR;
          pd_nxt = {6'h00, `IO_CFG_MODE_REQ};
          wr_nxt = 1'b1;
        end
      end
      S_PROG: begin
        if (wr && addr == `HOST_CTRL_ADDR && wdata[1]) wr_nxt = 1'b1;
        if (wr && addr == `HOST_CTRL_ADDR && wdata[2]) st_nxt = S_SYNC;
      end
      S_SYNC: begin
        // pins are the only sources fit for several devices at once
        if (pin_r) begin
          sb_nxt = 1'b1;
        end else begin
          tx_nxt = 1'b1;
        end
        st_nxt = S_DATA;
      end
      S_DATA: go_nxt = 1'b1;
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= S_IDLE;
      cnt_r <= 16'h0;
      pa_r <= 5'h00;
      pd_r <= 8'h00;
      wr_r <= 1'b0;
      go_r <= 1'b0;
      tx_r <= 1'b0;
      sb_r <= 1'b0;
      pin_r <= 1'b0;
      rd_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pa_r <= pa_nxt;
      pd_r <= pd_nxt;
      wr_r <= wr_nxt;
      go_r <= go_nxt;
      tx_r <= tx_nxt;
      sb_r <= sb_nxt;
      pin_r <= pin_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign lnk.reset_low_pin     = (st_r != S_RESET);
  assign lnk.sample_clock_en   = (st_r != S_IDLE) && (st_r != S_RESET);
  assign lnk.reg_wr            = wr_r;
  assign lnk.reg_addr          = pa_r;
  assign lnk.reg_wdata         = pd_r;
  assign lnk.transmit_gate_pin = tx_r;
  assign lnk.align_strobe_pin  = sb_r;
  assign lnk.data_valid        = go_r;
  assign rdata                 = rd_r;
endmodule // dac_sync_host
`default_nettype wire

// ==== sync_seq_chk.sv ====
// checker for the startup and sync link between host and device
`timescale 1ns/1ns
`default_nettype none
`include "sync_seq_map.svh"
module sync_seq_chk (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // link
  input wire logic       reset_low_pin,
  input wire logic       sample_clock_en,
  input wire logic       reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       transmit_gate_pin,
  input wire logic       align_strobe_pin,
  input wire logic       data_valid,
  input wire logic       dev_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // history of the current link reset period
  logic seen_wr_r, seen_wr_nxt, synced_r, synced_nxt;
  always_comb begin
    seen_wr_nxt = reset_low_pin & (seen_wr_r | reg_wr);
    synced_nxt  = reset_low_pin & (synced_r | transmit_gate_pin | align_strobe_pin
                  | (reg_wr & (reg_addr == `SYNC_CTRL_ADDR) & reg_wdata[`SYNC_CTRL_SW_BIT]));
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seen_wr_r <= 1'b0;
      synced_r  <= 1'b0;
    end else begin
      seen_wr_r <= seen_wr_nxt;
      synced_r  <= synced_nxt;
    end
  end
  // ==========================================================
  // assertions
  a_reset_pulse_len: assert property ($fell(reset_low_pin) |-> !reset_low_pin [*7])
    else $error("link reset pulse too short");
  a_no_write_reset: assert property (reg_wr |-> reset_low_pin && sample_clock_en)
    else $error("register write without clock or in reset");
  a_clock_after_rst: assert property (sample_clock_en |-> reset_low_pin)
    else $error("clock enabled during link reset");
  a_clock_settle: assert property ($rose(sample_clock_en) |-> !reg_wr [*8])
    else $error("write before clock settled");
  a_first_write_io: assert property (reg_wr && !seen_wr_r |->
      reg_addr == `IO_CFG_ADDR && reg_wdata[1:0] == `IO_CFG_MODE_REQ)
    else $error("first write is not the io mode setting");
  a_sync_after_prog: assert property ($rose(transmit_gate_pin) || align_strobe_pin |-> seen_wr_r)
    else $error("sync before programming");
  a_data_after_sync: assert property (data_valid |-> synced_r)
    else $error("data before sync");
  a_data_follows: assert property ($rose(transmit_gate_pin) || align_strobe_pin |-> ##[1:4] data_valid)
    else $error("no data after sync");
  a_strobe_pulse: assert property (align_strobe_pin |=> !align_strobe_pin)
    else $error("strobe longer than one cycle");
  c_gate: cover property ($rose(transmit_gate_pin));
  c_strobe: cover property (align_strobe_pin);
  c_data: cover property ($rose(data_valid) && dev_ready);
endmodule // sync_seq_chk
`default_nettype wire

// ==== tb.sv ====
// testbench: host and device joined over the link, driven from the software port
`timescale 1ns/1ns
`default_nettype none
`include "sync_seq_map.svh"
module tb;
  typedef struct {logic [7:0] sa, sb, cmd, d; logic upd;} row_t;
  logic       ref_clk, rst, wr, rd, cfg_ok, sync_seen, out_valid;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, io_cfg;
  logic [7:0] active_cfg [8];
  logic [1:0] out_skew;
  int         fails, n_compared;
  // sel_a, sel_b, host ctrl command, shadow data, copy expected
  row_t rows [5] = '{'{8'h00, 8'h00, 8'h04, 8'h3C, 1'b1}, '{8'h01, 8'h00, 8'h0C, 8'hC3, 1'b1},
                     '{8'h01, 8'h00, 8'h04, 8'h5A, 1'b0}, '{8'h00, 8'h02, 8'h0C, 8'h96, 1'b1},
                     '{8'h03, 8'h00, 8'h04, 8'h81, 1'b0}};
  sync_seq_if lnk ();
  dac_sync_host dac_sync_host_inst (.ref_clk(ref_clk), .rst(rst), .lnk(lnk.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  dac_sync_device dac_sync_device_inst (.ref_clk(ref_clk), .rst(rst), .lnk(lnk.dev),
    .active_cfg(active_cfg), .io_cfg(io_cfg), .cfg_ok(cfg_ok), .sync_seen(sync_seen),
    .out_valid(out_valid), .out_skew(out_skew));
  sync_seq_chk sync_seq_chk_inst (.ref_clk(ref_clk), .rst(rst), .reset_low_pin(lnk.reset_low_pin),
    .sample_clock_en(lnk.sample_clock_en), .reg_wr(lnk.reg_wr), .reg_addr(lnk.reg_addr),
    .reg_wdata(lnk.reg_wdata), .transmit_gate_pin(lnk.transmit_gate_pin),
    .align_strobe_pin(lnk.align_strobe_pin), .data_valid(lnk.data_valid), .dev_ready(lnk.dev_ready));
  // ==========================================================
  // tasks
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask
  task automatic sw_rd(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    cmp(rdata & mask, exp);
  endtask
  task automatic dev_wr(input logic [4:0] a, input logic [7:0] d);
    sw_wr(`HOST_WADDR_ADDR, {3'h0, a});
    sw_wr(`HOST_WDATA_ADDR, d);
    sw_wr(`HOST_CTRL_ADDR, 8'h02);
    cyc(2);
  endtask
  task automatic start_link;
    int k;
    k = 0;
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    cyc(1);
    cmp(io_cfg, `IO_CFG_RESET);
    cmp({7'h00, cfg_ok}, 8'h00);
    sw_wr(`HOST_CTRL_ADDR, 8'h01);
    // bounded wait for the host's own io mode write
    while (!(lnk.reg_wr === 1'b1 && lnk.reg_addr === `IO_CFG_ADDR) && k < 300) begin
      cyc(1);
      k++;
    end
    if (k >= 300) begin
      fails++;
      finish_test();
    end
    cyc(2);
    cmp({6'h00, io_cfg[1:0]}, {6'h00, `IO_CFG_MODE_REQ});
    cmp({7'h00, cfg_ok}, 8'h01);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00;
    fails = 0; n_compared = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      start_link();
      dev_wr(`SYNC_SEL_A_ADDR, rows[i].sa);
      dev_wr(`SYNC_SEL_B_ADDR, rows[i].sb);
      dev_wr(`SHADOW_FIRST_ADDR, rows[i].d);
      dev_wr(`SHADOW_LAST_ADDR, ~rows[i].d);
      cmp(active_cfg[0], 8'h00);
      sw_wr(`HOST_CTRL_ADDR, rows[i].cmd);
      cyc(5);
      cmp(active_cfg[0], rows[i].upd ? rows[i].d : 8'h00);
      cmp(active_cfg[7], rows[i].upd ? ~rows[i].d : 8'h00);
      cmp({7'h00, sync_seen}, {7'h00, rows[i].upd});
      cmp({7'h00, out_skew[1]}, 8'h00);
      cmp({7'h00, out_valid}, {7'h00, rows[i].upd});
    end
    // software sync in dual synchronous clock mode
    start_link();
    dev_wr(`SYNC_SEL_A_ADDR, 8'h02);
    dev_wr(`SHADOW_FIRST_ADDR, 8'hA5);
    cmp(active_cfg[0], 8'h00);
    dev_wr(`SYNC_CTRL_ADDR, 8'h05);
    cyc(2);
    cmp(active_cfg[0], 8'hA5);
    // one write of the bit is one event: a later shadow write waits
    dev_wr(`SHADOW_FIRST_ADDR, 8'h5A);
    cyc(2);
    cmp(active_cfg[0], 8'hA5);
    sw_wr(`HOST_CTRL_ADDR, 8'h04);
    cyc(5);
    cmp({6'h00, out_skew}, 8'h00);
    cmp({7'h00, out_valid}, 8'h01);
    // software port read back; unmapped reads return zero
    sw_rd(`HOST_WADDR_ADDR, 8'hFF, {3'h0, `SHADOW_FIRST_ADDR});
    sw_rd(`HOST_WDATA_ADDR, 8'hFF, 8'h5A);
    sw_rd(`HOST_STAT_ADDR, 8'h08, 8'h08);
    sw_rd(4'hF, 8'hFF, 8'h00);
    cyc(2);
    finish_test();
  end
endmodule // tb
`default_nettype wire
